// >>> logic/exec_pkg.sv
package exec_pkg;

  // ----------------------------------------
  // Operation codes presented by the fetch stage
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NONE         = 5'h00,
    OP_FILL_ONES    = 5'h01,
    OP_SET_BIT      = 5'h02,
    OP_INCR_SKIP    = 5'h03,
    OP_INCR_ACC_SKP = 5'h04,
    OP_DECR_ACC_SKP = 5'h05,
    OP_SKIP_BIT_SET = 5'h06,
    OP_SKIP_BIT_CLR = 5'h07,
    OP_SKIP_ZERO    = 5'h08,
    OP_COPY_SKIP    = 5'h09,
    OP_SUB_ACC      = 5'h0a,
    OP_SUB_MEM      = 5'h0b,
    OP_SUB_IMM      = 5'h0c,
    OP_SWAP_MEM     = 5'h0d,
    OP_SWAP_ACC     = 5'h0e,
    OP_TAB_PAGED    = 5'h0f,
    OP_TAB_LAST     = 5'h10,
    OP_XOR_ACC      = 5'h11
  } op_t;

  // ----------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_TABLE = 4'b0100,
    ST_DUMMY = 4'b1000
  } state_t;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] TABLE_HIGH_BYTE_REG_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ONE = 8'h01;

  // Flag bit positions in the status vector
  localparam int FLAG_C = 0;
  localparam int FLAG_HC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Cycles taken by a skipping instruction
  localparam int SKIP_CYCLES = 2;

endpackage

// >>> logic/exec_mem_if.sv
`timescale 1ns/10ps
// Table-read request and answer between executor and the latch module
interface exec_mem_if #(parameter int DATA_W = 8);
  logic req;
  logic [15:0] word;
  logic [DATA_W-1:0] low;
  logic [DATA_W-1:0] high;

  modport exec (output req, output word, input low, input high);
  modport latch (input req, input word, output low, output high);
endinterface

// >>> logic/table_latch.sv
`timescale 1ns/10ps
// ----------------------------------------
// Registered split of a program word
// ----------------------------------------
module table_latch (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Carrier
  exec_mem_if.latch bus
);

  logic [7:0] low_q;
  logic [7:0] high_q;

  // Capture the word when requested
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_q <= 8'h00;
      high_q <= 8'h00;
    end else if (bus.req) begin
      low_q <= bus.word[7:0];
      high_q <= bus.word[15:8];
    end
  end

  assign bus.low = low_q;
  assign bus.high = high_q;

endmodule

// >>> logic/skip_exec.sv
`timescale 1ns/10ps
// Operation
// - Fill ones writes FFH, flags untouched
// - Set bit touches only selected bit
// - Skip-type operations take two cycles when they skip, one otherwise
// - Increment memory, write back, skip on zero
// - Increment into accumulator, skip on zero
// - Skip when selected bit is one
// - Accumulator minus memory into accumulator
// - Carry clear on negative, else set
// - Subtraction updates overflow, zero, half, carry
// - Accumulator minus memory into memory
// - Accumulator minus immediate into accumulator
// - Swap nibbles in place, flags untouched
// - Swap into accumulator, memory untouched
// - Skip when byte is zero
// - Copy to accumulator, skip on zero
// - Skip when selected bit is zero
// - Paged table read to memory and high
// - Last-page table read to memory and high
// - XOR into accumulator, update zero flag
// - Decrement into accumulator, skip on zero
module skip_exec #(
  parameter int PC_W = 13,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Instruction from fetch
  input wire logic op_valid_i,
  input wire exec_pkg::op_t op_i,
  input wire logic [ADDR_W-1:0] op_addr_i,
  input wire logic [2:0] op_bit_i,
  input wire logic [7:0] op_imm_i,
  output logic op_ready_o,
  // Pipeline control
  output logic skip_o,
  output logic busy_o,
  // Data memory
  output logic [ADDR_W-1:0] dmem_addr_o,
  input wire logic [7:0] dmem_rdata_i,
  output logic dmem_we_o,
  output logic [7:0] dmem_wdata_o,
  // Program memory
  output logic pmem_re_o,
  output logic [PC_W-1:0] pmem_addr_o,
  input wire logic [15:0] pmem_rdata_i,
  // Table pointers
  input wire logic [7:0] table_pointer_low_i,
  input wire logic [7:0] table_pointer_high_i,
  input wire logic has_high_ptr_i,
  // Architectural state
  output logic [7:0] acc_o,
  output logic [3:0] flags_o,
  output logic [7:0] table_high_byte_reg_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (PC_W < 9 || PC_W > 16) begin : g_pc_check
    $error("PC_W must be 9..16");
  end
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_addr_check
    $error("ADDR_W must be 1..16");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  exec_pkg::state_t state_q, state_d;
  exec_pkg::op_t op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0] bit_q;
  logic [7:0] imm_q;
  logic [7:0] acc_q, acc_d;
  logic [3:0] flags_q, flags_d;
  logic [7:0] table_high_byte_reg_q, table_high_byte_reg_d;
  logic skip_q, skip_d;
  logic we_q, we_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] taddr_q;

  exec_mem_if #(.DATA_W(8)) tab ();

  table_latch u_latch (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .bus(tab)
  );

  // Bit mask decode, used for set and tests
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  wire [7:0] mem = dmem_rdata_i;
  wire [7:0] inc_val = mem + exec_pkg::ONE;
  wire [7:0] dec_val = mem - exec_pkg::ONE;
  wire [7:0] swap_val = {mem[3:0], mem[7:4]};
  wire [7:0] sub_rhs = (op_q == exec_pkg::OP_SUB_IMM) ? imm_q : mem;
  wire [8:0] sub_full = {1'b0, acc_q} - {1'b0, sub_rhs};
  wire [7:0] sub_val = sub_full[7:0];
  wire [4:0] sub_low = {1'b0, acc_q[3:0]} - {1'b0, sub_rhs[3:0]};
  wire sub_c = ~sub_full[8];
  wire sub_hc = ~sub_low[4];
  wire sub_ov = (acc_q[7] ^ sub_rhs[7]) & (acc_q[7] ^ sub_val[7]);
  wire sel_bit = |(mem & bit_mask(bit_q));
  wire [7:0] xor_val = acc_q ^ mem;

  // Program word address for the two table forms
  wire [15:0] paged_addr = has_high_ptr_i ? {table_pointer_high_i, taddr_q} : {8'h00, taddr_q};
  wire [15:0] last_addr = {{(16 - PC_W){1'b0}}, {(PC_W - 8){1'b1}}, taddr_q};
  wire [15:0] tab_addr = (op_q == exec_pkg::OP_TAB_LAST) ? last_addr : paged_addr;

  // Capture the program word while the read is enabled, since an idle program bus does not carry the addressed word
  assign tab.req = pmem_re_o;
  assign tab.word = pmem_rdata_i;

  // ----------------------------------------
  // Execute step
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    flags_d = flags_q;
    table_high_byte_reg_d = table_high_byte_reg_q;
    skip_d = 1'b0;
    we_d = 1'b0;
    wdata_d = wdata_q;
    unique case (state_q)
      exec_pkg::ST_IDLE: begin
        if (op_valid_i) begin
          state_d = exec_pkg::ST_EXEC;
        end
      end
      exec_pkg::ST_EXEC: begin
        state_d = exec_pkg::ST_IDLE;
        unique case (op_q)
          exec_pkg::OP_FILL_ONES: begin
            we_d = 1'b1;
            wdata_d = exec_pkg::ALL_ONES;
          end
          exec_pkg::OP_SET_BIT: begin
            we_d = 1'b1;
            wdata_d = mem | bit_mask(bit_q);
          end
          exec_pkg::OP_INCR_SKIP: begin
            we_d = 1'b1;
            wdata_d = inc_val;
            skip_d = (inc_val == 8'h00);
          end
          exec_pkg::OP_INCR_ACC_SKP: begin
            acc_d = inc_val;
            skip_d = (inc_val == 8'h00);
          end
          exec_pkg::OP_DECR_ACC_SKP: begin
            acc_d = dec_val;
            skip_d = (dec_val == 8'h00);
          end
          exec_pkg::OP_SKIP_BIT_SET: begin
            skip_d = sel_bit;
          end
          exec_pkg::OP_SKIP_BIT_CLR: begin
            skip_d = ~sel_bit;
          end
          exec_pkg::OP_SKIP_ZERO: begin
            skip_d = (mem == 8'h00);
          end
          exec_pkg::OP_COPY_SKIP: begin
            acc_d = mem;
            skip_d = (mem == 8'h00);
          end
          exec_pkg::OP_SUB_ACC, exec_pkg::OP_SUB_IMM, exec_pkg::OP_SUB_MEM: begin
            if (op_q == exec_pkg::OP_SUB_MEM) begin
              we_d = 1'b1;
              wdata_d = sub_val;
            end else begin
              acc_d = sub_val;
            end
            flags_d[exec_pkg::FLAG_C] = sub_c;
            flags_d[exec_pkg::FLAG_HC] = sub_hc;
            flags_d[exec_pkg::FLAG_OV] = sub_ov;
            flags_d[exec_pkg::FLAG_Z] = (sub_val == 8'h00);
          end
          exec_pkg::OP_SWAP_MEM: begin
            we_d = 1'b1;
            wdata_d = swap_val;
          end
          exec_pkg::OP_SWAP_ACC: begin
            acc_d = swap_val;
          end
          exec_pkg::OP_TAB_PAGED, exec_pkg::OP_TAB_LAST: begin
            state_d = exec_pkg::ST_TABLE;
          end
          exec_pkg::OP_XOR_ACC: begin
            acc_d = xor_val;
            flags_d[exec_pkg::FLAG_Z] = (xor_val == 8'h00);
          end
          default: begin
          end
        endcase
        if (skip_d) begin
          state_d = exec_pkg::ST_DUMMY;
        end
      end
      exec_pkg::ST_TABLE: begin
        state_d = exec_pkg::ST_IDLE;
        we_d = 1'b1;
        wdata_d = tab.low;
        table_high_byte_reg_d = tab.high;
      end
      exec_pkg::ST_DUMMY: begin
        // Dummy slot replaces the skipped instruction
        state_d = exec_pkg::ST_IDLE;
      end
      default: begin
        state_d = exec_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= exec_pkg::ST_IDLE;
      acc_q <= exec_pkg::ACC_RESET;
      flags_q <= exec_pkg::FLAGS_RESET;
      table_high_byte_reg_q <= exec_pkg::TABLE_HIGH_BYTE_REG_RESET;
      skip_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      table_high_byte_reg_q <= table_high_byte_reg_d;
      skip_q <= skip_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
    end
  end

  // Operand capture when an instruction is accepted
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_q <= exec_pkg::OP_NONE;
      addr_q <= '0;
      bit_q <= 3'h0;
      imm_q <= 8'h00;
      taddr_q <= 8'h00;
    end else if (op_ready_o && op_valid_i) begin
      op_q <= op_i;
      addr_q <= op_addr_i;
      bit_q <= op_bit_i;
      imm_q <= op_imm_i;
      taddr_q <= table_pointer_low_i;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign op_ready_o = (state_q == exec_pkg::ST_IDLE);
  assign busy_o = ~op_ready_o;
  assign skip_o = skip_q;
  assign dmem_addr_o = addr_q;
  assign dmem_we_o = we_q;
  assign dmem_wdata_o = wdata_q;
  assign pmem_re_o = (state_q == exec_pkg::ST_EXEC) &&
                     (op_q == exec_pkg::OP_TAB_PAGED || op_q == exec_pkg::OP_TAB_LAST);
  assign pmem_addr_o = tab_addr[PC_W-1:0];
  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign table_high_byte_reg_o = table_high_byte_reg_q;

endmodule

// >>> tb/mem_model.sv
`timescale 1ns/10ps
// ------
// Data and program memory beside the core
// ------
module mem_model (
  // Clock
  input wire logic clk_i,
  // Data side
  input wire logic [7:0] dmem_addr_i,
  input wire logic dmem_we_i,
  input wire logic [7:0] dmem_wdata_i,
  output logic [7:0] dmem_rdata_o,
  // Program side
  input wire logic pmem_re_i,
  input wire logic [12:0] pmem_addr_i,
  output logic [15:0] pmem_rdata_o
);
  logic [7:0] mem [256];
  logic [15:0] word;
  // Combinational reads; an idle program bus shows the inverse word
  assign dmem_rdata_o = mem[dmem_addr_i];
  assign word = {pmem_addr_i[7:0] ^ 8'h5c, 3'h0, pmem_addr_i[12:8]};
  assign pmem_rdata_o = pmem_re_i ? word : ~word;
  // Byte write on the strobe
  always @(posedge clk_i) begin
    if (dmem_we_i) begin
      mem[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule

// >>> tb/skip_exec_sva.sv
`timescale 1ns/10ps
// ------
// Port checker
// ------
module skip_exec_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Watched ports
  input wire logic op_valid_i,
  input wire exec_pkg::op_t op_i,
  input wire logic op_ready_o,
  input wire logic skip_o,
  input wire logic busy_o,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic dmem_we_o,
  input wire logic [7:0] dmem_wdata_o,
  input wire logic pmem_re_o,
  input wire logic [7:0] acc_o,
  input wire logic [3:0] flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic take;
  logic [7:0] swp;
  // Accepted request and swapped operand
  assign take = op_valid_i && op_ready_o;
  assign swp = {dmem_rdata_i[3:0], dmem_rdata_i[7:4]};
  chk_ready_busy: assert property (busy_o == !op_ready_o)
    else $error("busy and ready disagree");
  chk_fill_byte: assert property (take && op_i == exec_pkg::OP_FILL_ONES |-> ##2 dmem_we_o && dmem_wdata_o == 8'hff)
    else $error("fill did not write all ones");
  chk_fill_flags: assert property (take && op_i == exec_pkg::OP_FILL_ONES |-> ##2 flags_o == $past(flags_o, 2))
    else $error("fill changed flags");
  chk_skip_len: assert property (skip_o |-> busy_o ##1 op_ready_o)
    else $error("skip cycle count wrong");
  chk_skip_pulse: assert property (skip_o |=> !skip_o)
    else $error("skip longer than one cycle");
  chk_sub_carry: assert property (take && op_i == exec_pkg::OP_SUB_ACC |=> ##1
    acc_o == $past(acc_o) - $past(dmem_rdata_i) && flags_o[0] == ($past(acc_o) >= $past(dmem_rdata_i)))
    else $error("subtract result or carry wrong");
  chk_xor_zero: assert property (take && op_i == exec_pkg::OP_XOR_ACC |=> ##1
    acc_o == ($past(acc_o) ^ $past(dmem_rdata_i)) && flags_o[2] == (acc_o == 8'h00))
    else $error("xor result or zero flag wrong");
  chk_zero_skip: assert property (take && op_i == exec_pkg::OP_SKIP_ZERO |=> ##1 skip_o == ($past(dmem_rdata_i) == 8'h00))
    else $error("zero skip wrong");
  chk_swap_acc: assert property (take && op_i == exec_pkg::OP_SWAP_ACC |=> ##1 !dmem_we_o && acc_o == $past(swp))
    else $error("swap to accumulator wrong");
  chk_table_read: assert property (take && op_i == exec_pkg::OP_TAB_PAGED |=> pmem_re_o)
    else $error("table read did not reach program memory");
  // Main scenarios
  cover property (skip_o);
  cover property (take && op_i == exec_pkg::OP_TAB_LAST);
  cover property (dmem_we_o && dmem_wdata_o == 8'h00);
endmodule
bind skip_exec skip_exec_sva skip_exec_sva_inst (.clk_i, .rstn_i, .op_valid_i, .op_i, .op_ready_o, .skip_o,
  .busy_o, .dmem_rdata_i, .dmem_we_o, .dmem_wdata_o, .pmem_re_o, .acc_o, .flags_o);

// >>> tb/mcu_skip_sub_swap_table_ops_test.sv
`timescale 1ns/10ps
module mcu_skip_sub_swap_table_ops_test;
  logic clk_i, rstn_i, op_valid_i, has_high_ptr_i, op_ready_o, skip_o, busy_o, dmem_we_o, pmem_re_o;
  exec_pkg::op_t op_i;
  logic [7:0] op_addr_i, op_imm_i, table_pointer_low_i, table_pointer_high_i, dmem_addr_o, dmem_rdata_i;
  logic [7:0] dmem_wdata_o, acc_o, table_high_byte_reg_o, acc_e, table_high_byte_reg_e;
  logic [2:0] op_bit_i;
  logic [3:0] flags_o, flg_e;
  logic [12:0] pmem_addr_o;
  logic [15:0] pmem_rdata_i;
  logic [15:0] wq [$];
  logic [7:0] ref_m [256];
  int miscompares, total_checks;
  int seed = 32'h1012_56ee;
  skip_exec skip_exec_inst (.clk_i, .rstn_i, .op_valid_i, .op_i, .op_addr_i, .op_bit_i, .op_imm_i, .op_ready_o,
    .skip_o, .busy_o, .dmem_addr_o, .dmem_rdata_i, .dmem_we_o, .dmem_wdata_o, .pmem_re_o, .pmem_addr_o,
    .pmem_rdata_i, .table_pointer_low_i, .table_pointer_high_i, .has_high_ptr_i, .acc_o, .flags_o,
    .table_high_byte_reg_o);
  mem_model mem_model_inst (.clk_i, .dmem_addr_i(dmem_addr_o), .dmem_we_i(dmem_we_o), .dmem_wdata_i(dmem_wdata_o),
    .dmem_rdata_o(dmem_rdata_i), .pmem_re_i(pmem_re_o), .pmem_addr_i(pmem_addr_o), .pmem_rdata_o(pmem_rdata_i));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Each memory write takes the oldest expected write
  always @(posedge clk_i) begin
    if (dmem_we_o === 1'b1) begin
      if (wq.size() == 0) begin
        check("stray write", 16'h0001, 16'h0000);
      end else begin
        check("write", {dmem_addr_o, dmem_wdata_o}, wq.pop_front());
      end
    end
  end
  // One instruction with its predicted effects
  task automatic run(input exec_pkg::op_t op);
    logic [7:0] a, m, s, d, w, src;
    logic [12:0] pa;
    logic [15:0] pw;
    logic sk, sk_e, wr, tab;
    int r, r2, n;
    r = $random(seed);
    r2 = $random(seed);
    a = r[7:0];
    s = r[31:24];
    if (r[14]) begin
      ref_m[a] = {8{r[13]}} | {7'h00, r[12]};
      mem_model_inst.mem[a] = ref_m[a];
    end
    m = ref_m[a];
    w = m;
    src = (op == exec_pkg::OP_SUB_IMM) ? s : m;
    d = acc_e - src;
    pa = (op == exec_pkg::OP_TAB_LAST) ? {5'h1f, r[23:16]} : {r[15] ? r2[4:0] : 5'h00, r[23:16]};
    pw = {pa[7:0] ^ 8'h5c, 3'h0, pa[12:8]};
    wr = op inside {exec_pkg::OP_FILL_ONES, exec_pkg::OP_SET_BIT, exec_pkg::OP_INCR_SKIP, exec_pkg::OP_SUB_MEM,
      exec_pkg::OP_SWAP_MEM, exec_pkg::OP_TAB_PAGED, exec_pkg::OP_TAB_LAST};
    tab = op inside {exec_pkg::OP_TAB_PAGED, exec_pkg::OP_TAB_LAST};
    sk_e = 1'b0;
    if (op inside {exec_pkg::OP_SUB_ACC, exec_pkg::OP_SUB_MEM, exec_pkg::OP_SUB_IMM}) begin
      flg_e = {(acc_e[7] != src[7]) && (d[7] != acc_e[7]), d == 8'h00, acc_e[3:0] >= src[3:0], acc_e >= src};
    end
    case (op)
      exec_pkg::OP_FILL_ONES: w = 8'hff;
      exec_pkg::OP_SET_BIT: w = m | (8'h01 << r[10:8]);
      exec_pkg::OP_INCR_SKIP: w = m + 8'h01;
      exec_pkg::OP_INCR_ACC_SKP: acc_e = m + 8'h01;
      exec_pkg::OP_DECR_ACC_SKP: acc_e = m - 8'h01;
      exec_pkg::OP_SKIP_BIT_SET: sk_e = m[r[10:8]];
      exec_pkg::OP_SKIP_BIT_CLR: sk_e = !m[r[10:8]];
      exec_pkg::OP_SKIP_ZERO: sk_e = (m == 8'h00);
      exec_pkg::OP_COPY_SKIP: acc_e = m;
      exec_pkg::OP_SUB_MEM: w = d;
      exec_pkg::OP_SUB_ACC, exec_pkg::OP_SUB_IMM: acc_e = d;
      exec_pkg::OP_SWAP_MEM: w = {m[3:0], m[7:4]};
      exec_pkg::OP_SWAP_ACC: acc_e = {m[3:0], m[7:4]};
      exec_pkg::OP_XOR_ACC: acc_e = acc_e ^ m;
      default: w = pw[7:0];
    endcase
    if (tab) table_high_byte_reg_e = pw[15:8];
    if (op == exec_pkg::OP_XOR_ACC) flg_e[2] = (acc_e == 8'h00);
    if (op == exec_pkg::OP_INCR_SKIP) sk_e = (w == 8'h00);
    if (op inside {exec_pkg::OP_INCR_ACC_SKP, exec_pkg::OP_DECR_ACC_SKP, exec_pkg::OP_COPY_SKIP}) sk_e = (acc_e == 8'h00);
    if (wr) wq.push_back({a, w});
    if (wr) ref_m[a] = w;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    op_addr_i <= a;
    op_bit_i <= r[10:8];
    op_imm_i <= s;
    table_pointer_low_i <= r[23:16];
    table_pointer_high_i <= r2[7:0];
    has_high_ptr_i <= r[15];
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    n = 0;
    sk = 1'b0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      sk |= skip_o;
    end while (op_ready_o !== 1'b1 && n < 8);
    check("cycles", 16'(n), 16'((sk_e || tab) ? 2 : 1));
    check("skip", sk, sk_e);
    check("acc", acc_o, acc_e);
    check("flags", flags_o, flg_e);
    check("table_high_byte_reg", table_high_byte_reg_o, table_high_byte_reg_e);
    // Let the predicted write land before the next direct memory poke
    if (wr) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // Reset, then every operation in turn
  initial begin
    rstn_i = 1'b0;
    op_valid_i = 1'b0;
    op_i = exec_pkg::OP_NONE;
    op_addr_i = 8'h00;
    op_bit_i = 3'h0;
    op_imm_i = 8'h00;
    table_pointer_low_i = 8'h00;
    table_pointer_high_i = 8'h00;
    has_high_ptr_i = 1'b0;
    acc_e = exec_pkg::ACC_RESET;
    flg_e = exec_pkg::FLAGS_RESET;
    table_high_byte_reg_e = exec_pkg::TABLE_HIGH_BYTE_REG_RESET;
    for (int i = 0; i < 256; i++) begin
      ref_m[i] = $random(seed);
      mem_model_inst.mem[i] = ref_m[i];
    end
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int k = 0; k < 340; k++) begin
      run(exec_pkg::op_t'(k % 17 + 1));
    end
    check("pending writes", 16'(wq.size()), 16'h0000);
    test_done();
  end
  // Watchdog
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule
